//--- hdl/pmt_cfg.svh
// register offsets, field positions, reset values and timing for the timer
`ifndef PMT_CFG_SVH
`define PMT_CFG_SVH
`define PMT_OFF_CONTROL 4'h0
`define PMT_OFF_COUNT 4'h4
`define PMT_OFF_PERIOD 4'h8
`define PMT_OFF_FLAG 4'hc
`define PMT_PRE_LSB 0
`define PMT_ON_BIT 2
`define PMT_POST_LSB 3
`define PMT_CONTROL_RST 8'h00
`define PMT_PERIOD_RST 8'hff
`define PMT_COUNT_RST 8'h00
`define PMT_INSTR_DIV 2'h3
`define PMT_FLAG_BIT 0
`define PMT_ENABLE_BIT 1
`endif

//--- hdl/pmt_pkg.sv
// types shared by the period match timer
package pmt_pkg;
    typedef enum logic [2:0] {
        PMT_BUS_IDLE = 3'b001,
        PMT_BUS_WRESP = 3'b010,
        PMT_BUS_RDATA = 3'b100
    } pmt_bus_state_t;
    typedef logic [7:0] pmt_byte_t;
endpackage

//--- hdl/pmt_prescaler.sv
// prescaler: instruction clock divider feeding the count tick
`timescale 1ns/10ps
`include "pmt_cfg.svh"
module pmt_prescaler
    import pmt_pkg::*;
(
    input wire logic clk_in,        // system clock
    input wire logic rst_n_in,      // synced reset, active low
    input wire logic ce_in,         // clock enable
    input wire logic run_in,        // timer on and awake
    input wire logic clear_in,      // clear the divider chain
    input wire logic [1:0] sel_in,  // prescale select
    output logic tick_out           // one-cycle count pulse
);
    typedef struct packed {
        logic [1:0] quarter;
        logic [5:0] div;
    } pmt_pre_state_t;
    pmt_pre_state_t st_reg, st_next;
    logic instr;
    logic [5:0] limit;

    always_comb begin
        st_next = st_reg;
        instr = (st_reg.quarter == `PMT_INSTR_DIV);
        unique case (sel_in)
            2'h0: limit = 6'h00;
            2'h1: limit = 6'h03;
            2'h2: limit = 6'h0f;
            2'h3: limit = 6'h3f;
        endcase
        tick_out = 1'b0;
        if (clear_in) begin
            st_next = '0;
        end else if (run_in) begin
            st_next.quarter = st_reg.quarter + 2'h1;
            if (instr) begin
                if (st_reg.div >= limit) begin
                    st_next.div = 6'h00;
                    tick_out = 1'b1;
                end else begin
                    st_next.div = st_reg.div + 6'h01;
                end
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_reg <= '0;
        end else if (ce_in) begin
            st_reg <= st_next;
        end
    end
endmodule

//--- hdl/pmt_postscaler.sv
// postscaler: counts match events and signals each n+1th
`timescale 1ns/10ps
`include "pmt_cfg.svh"
module pmt_postscaler
    import pmt_pkg::*;
(
    input wire logic clk_in,        // system clock
    input wire logic rst_n_in,      // synced reset, active low
    input wire logic ce_in,         // clock enable
    input wire logic clear_in,      // clear the counter
    input wire logic match_in,      // match event
    input wire logic [3:0] sel_in,  // postscale select
    output logic done_out           // one-cycle flag event
);
    typedef struct packed {
        logic [3:0] cnt;
    } pmt_post_state_t;
    pmt_post_state_t st_reg, st_next;

    always_comb begin
        st_next = st_reg;
        done_out = 1'b0;
        if (clear_in) begin
            st_next = '0;
        end else if (match_in) begin
            if (st_reg.cnt >= sel_in) begin
                st_next.cnt = 4'h0;
                done_out = 1'b1;
            end else begin
                st_next.cnt = st_reg.cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_reg <= '0;
        end else if (ce_in) begin
            st_reg <= st_next;
        end
    end
endmodule

//--- hdl/pmt_timer.sv
// top of the 8-bit period match timer with its AXI4-Lite slave
// What this block does
// - counting clock is the system clock divided by four
// - count register increments by one per prescaled tick, from zero
// - control bits 1-0 pick prescale 1, 4, 16 or 64
// - count compared with period at each prescaled tick; equality gives match
// - match clears count next cycle and advances postscaler
// - reset clears count and sets period to all ones
// - count write, control write and reset clear both scalers
// - control write leaves the count register unchanged
// - control bits 6-3 value n gives one flag per n+1 matches
// - postscaler completion sets flag; interrupt only when enabled
// - match pulse is synchronous and exported to other peripherals
// - control bit 2 turns the timer on or off
// - in sleep the timer does not count; registers hold
// - count and period are readable and writable at any time
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "pmt_cfg.svh"
module pmt_timer
    import pmt_pkg::*;
(
    input wire logic MCLK_IN,             // 250 MHz system clock
    input wire logic RST_N_IN,            // async reset, active low
    input wire logic CE_IN,               // clock enable, freezes state
    input wire logic SLEEP_IN,            // processor in sleep
    input wire logic [3:0] AWADDR_IN,     // write address
    input wire logic AWVALID_IN,          // write address valid
    output logic AWREADY_OUT,             // write address ready
    input wire logic [31:0] WDATA_IN,     // write data
    input wire logic [3:0] WSTRB_IN,      // write strobes
    input wire logic WVALID_IN,           // write data valid
    output logic WREADY_OUT,              // write data ready
    output logic [1:0] BRESP_OUT,         // write response
    output logic BVALID_OUT,              // write response valid
    input wire logic BREADY_IN,           // write response ready
    input wire logic [3:0] ARADDR_IN,     // read address
    input wire logic ARVALID_IN,          // read address valid
    output logic ARREADY_OUT,             // read address ready
    output logic [31:0] RDATA_OUT,        // read data
    output logic [1:0] RRESP_OUT,         // read response
    output logic RVALID_OUT,              // read data valid
    input wire logic RREADY_IN,           // read data ready
    output logic PERIOD_MATCH_PULSE_OUT,  // match pulse to peripherals
    output logic MATCH_IRQ_OUT            // interrupt request
);
    typedef struct packed {
        pmt_bus_state_t wst;
        pmt_bus_state_t rst;
        logic aw_got;
        logic w_got;
        logic [3:0] awaddr;
        logic [31:0] wdata;
        logic wstrb0;
        logic [1:0] bresp;
        logic [31:0] rdata;
        logic [1:0] rresp;
        pmt_byte_t control;
        pmt_byte_t count;
        pmt_byte_t period;
        logic flag;
        logic enable;
        logic clr_pend;
        logic match;
        logic irq;
        logic aw_rdy;
        logic w_rdy;
        logic b_vld;
        logic ar_rdy;
        logic r_vld;
    } pmt_state_t;
    pmt_state_t st_reg, st_next;

    logic [1:0] rst_sync_reg;
    logic rst_n;
    logic run;
    logic tick;
    logic post_done;
    logic wr_fire;
    logic wr_ctrl;
    logic wr_count;
    logic scaler_clear;
    logic eq;
    logic wr_period;
    logic wr_flag;
    logic wr_err;
    logic rd_err;
    logic [7:0] rd_byte;

    // reset released through two flops
    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    assign wr_fire = st_reg.aw_got && st_reg.w_got
        && (st_reg.wst == PMT_BUS_IDLE);
    assign wr_ctrl = wr_fire && st_reg.wstrb0
        && (st_reg.awaddr == `PMT_OFF_CONTROL);
    assign wr_count = wr_fire && st_reg.wstrb0
        && (st_reg.awaddr == `PMT_OFF_COUNT);
    assign wr_period = wr_fire && st_reg.wstrb0
        && (st_reg.awaddr == `PMT_OFF_PERIOD);
    assign wr_flag = wr_fire && st_reg.wstrb0
        && (st_reg.awaddr == `PMT_OFF_FLAG);
    assign scaler_clear = wr_ctrl || wr_count;
    assign run = st_reg.control[`PMT_ON_BIT] && !SLEEP_IN;
    assign eq = (st_reg.count == st_reg.period);

    pmt_prescaler u_pre (
        .clk_in(MCLK_IN),
        .rst_n_in(rst_n),
        .ce_in(CE_IN),
        .run_in(run),
        .clear_in(scaler_clear),
        .sel_in(st_reg.control[`PMT_PRE_LSB +: 2]),
        .tick_out(tick)
    );

    pmt_postscaler u_post (
        .clk_in(MCLK_IN),
        .rst_n_in(rst_n),
        .ce_in(CE_IN),
        .clear_in(scaler_clear),
        .match_in(st_reg.match),
        .sel_in(st_reg.control[`PMT_POST_LSB +: 4]),
        .done_out(post_done)
    );

    // write response code for the held address
    always_comb begin
        unique case (st_reg.awaddr)
            `PMT_OFF_CONTROL, `PMT_OFF_COUNT,
            `PMT_OFF_PERIOD, `PMT_OFF_FLAG: wr_err = 1'b0;
            default: wr_err = 1'b1;
        endcase
    end

    // read-back byte for the requested address
    always_comb begin
        rd_byte = 8'h00;
        rd_err = 1'b0;
        unique case (ARADDR_IN)
            `PMT_OFF_CONTROL: rd_byte = {1'b0, st_reg.control[6:0]};
            `PMT_OFF_COUNT: rd_byte = st_reg.count;
            `PMT_OFF_PERIOD: rd_byte = st_reg.period;
            `PMT_OFF_FLAG: rd_byte = {6'h00, st_reg.enable, st_reg.flag};
            default: rd_err = 1'b1;
        endcase
    end

    always_comb begin
        st_next = st_reg;
        // write address and data taken in either order
        if (!st_reg.aw_got && AWVALID_IN) begin
            st_next.aw_got = 1'b1;
            st_next.awaddr = AWADDR_IN;
        end
        if (!st_reg.w_got && WVALID_IN) begin
            st_next.w_got = 1'b1;
            st_next.wdata = WDATA_IN;
            st_next.wstrb0 = WSTRB_IN[0];
        end
        // write response state
        unique case (st_reg.wst)
            PMT_BUS_IDLE: begin
                if (wr_fire) begin
                    st_next.wst = PMT_BUS_WRESP;
                    st_next.bresp = wr_err ? 2'b10 : 2'b00;
                end
            end
            PMT_BUS_WRESP: begin
                if (BREADY_IN) begin
                    st_next.wst = PMT_BUS_IDLE;
                    st_next.aw_got = 1'b0;
                    st_next.w_got = 1'b0;
                end
            end
            default: st_next.wst = PMT_BUS_IDLE;
        endcase
        // read data state
        unique case (st_reg.rst)
            PMT_BUS_IDLE: begin
                if (ARVALID_IN) begin
                    st_next.rst = PMT_BUS_RDATA;
                    st_next.rresp = rd_err ? 2'b10 : 2'b00;
                    st_next.rdata = {24'h00_0000, rd_byte};
                end
            end
            PMT_BUS_RDATA: begin
                if (RREADY_IN) begin
                    st_next.rst = PMT_BUS_IDLE;
                end
            end
            default: st_next.rst = PMT_BUS_IDLE;
        endcase

        // counter: pending clear first, else one step per tick
        // match clears count
        if (st_reg.clr_pend && run) begin
            st_next.count = `PMT_COUNT_RST;
            st_next.clr_pend = 1'b0;
        end else if (tick) begin
            st_next.count = st_reg.count + 8'h01;
        end
        // match taken at a tick while count equals period
        // hold when off
        st_next.match = 1'b0;
        if (run && eq && tick) begin
            st_next.match = 1'b1;
            st_next.clr_pend = 1'b1;
            st_next.count = st_reg.count;
        end

        // register writes from the bus, unused strobe lanes ignored
        // count kept
        if (wr_ctrl) begin
            st_next.control = {1'b0, st_reg.wdata[6:0]};
        end
        // a count write also drops a pending clear
        if (wr_count) begin
            st_next.count = st_reg.wdata[7:0];
            st_next.clr_pend = 1'b0;
        end
        if (wr_period) begin
            st_next.period = st_reg.wdata[7:0];
        end
        if (wr_flag) begin
            st_next.flag = st_reg.wdata[`PMT_FLAG_BIT];
            st_next.enable = st_reg.wdata[`PMT_ENABLE_BIT];
        end
        if (post_done) begin
            st_next.flag = 1'b1;
        end
        // interrupt request follows flag and enable
        st_next.irq = st_next.flag && st_next.enable;
        // ready and valid outputs kept in flops of their own
        st_next.aw_rdy = !st_next.aw_got;
        st_next.w_rdy = !st_next.w_got;
        st_next.b_vld = (st_next.wst == PMT_BUS_WRESP);
        st_next.ar_rdy = (st_next.rst == PMT_BUS_IDLE);
        st_next.r_vld = (st_next.rst == PMT_BUS_RDATA);
    end

    always_ff @(posedge MCLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
            st_reg.wst <= PMT_BUS_IDLE;
            st_reg.rst <= PMT_BUS_IDLE;
            st_reg.control <= `PMT_CONTROL_RST;
            st_reg.count <= `PMT_COUNT_RST;
            st_reg.period <= `PMT_PERIOD_RST;
            st_reg.aw_rdy <= 1'b1;
            st_reg.w_rdy <= 1'b1;
            st_reg.ar_rdy <= 1'b1;
        end else if (CE_IN) begin
            st_reg <= st_next;
        end
    end

    // output ports straight from state flops
    assign AWREADY_OUT = st_reg.aw_rdy;
    assign WREADY_OUT = st_reg.w_rdy;
    assign BVALID_OUT = st_reg.b_vld;
    assign BRESP_OUT = st_reg.bresp;
    assign ARREADY_OUT = st_reg.ar_rdy;
    assign RVALID_OUT = st_reg.r_vld;
    assign RDATA_OUT = st_reg.rdata;
    assign RRESP_OUT = st_reg.rresp;
    assign PERIOD_MATCH_PULSE_OUT = st_reg.match;
    assign MATCH_IRQ_OUT = st_reg.irq;
endmodule

//--- dv/pmt_timer_asserts.sv
// checker on the bus handshakes, match pulse and interrupt of the timer
`timescale 1ns/10ps
module pmt_timer_asserts (
    input wire logic MCLK_IN,                 // clock
    input wire logic RST_N_IN,                // reset, active low
    input wire logic SLEEP_IN,                // sleep
    input wire logic AWVALID_IN,              // aw valid
    input wire logic AWREADY_OUT,             // aw ready
    input wire logic WVALID_IN,               // w valid
    input wire logic WREADY_OUT,              // w ready
    input wire logic [1:0] BRESP_OUT,         // b resp
    input wire logic BVALID_OUT,              // b valid
    input wire logic BREADY_IN,               // b ready
    input wire logic ARVALID_IN,              // ar valid
    input wire logic ARREADY_OUT,             // ar ready
    input wire logic [31:0] RDATA_OUT,        // r data
    input wire logic RVALID_OUT,              // r valid
    input wire logic RREADY_IN,               // r ready
    input wire logic PERIOD_MATCH_PULSE_OUT,  // match pulse
    input wire logic MATCH_IRQ_OUT            // irq
);
    default clocking cb @(posedge MCLK_IN);
    endclocking
    default disable iff (!RST_N_IN);
    a_match_spacing: assert property (
        PERIOD_MATCH_PULSE_OUT |=> !PERIOD_MATCH_PULSE_OUT [*3])
        else $error("match pulses closer than four cycles");
    a_sleep_quiet: assert property (
        SLEEP_IN [*4] |-> !PERIOD_MATCH_PULSE_OUT)
        else $error("match pulse during sleep");
    a_irq_fall_write: assert property (
        $fell(MATCH_IRQ_OUT) |-> BVALID_OUT || $past(BVALID_OUT))
        else $error("irq dropped without a write");
    a_write_answer: assert property (
        AWVALID_IN && AWREADY_OUT && WVALID_IN && WREADY_OUT
        |-> ##2 BVALID_OUT)
        else $error("write response late");
    a_read_answer: assert property (
        ARVALID_IN && ARREADY_OUT |=> RVALID_OUT)
        else $error("read data late");
    a_bresp_hold: assert property (
        BVALID_OUT && !BREADY_IN |=> BVALID_OUT && $stable(BRESP_OUT))
        else $error("write response not held");
    a_rdata_hold: assert property (
        RVALID_OUT && !RREADY_IN |=> RVALID_OUT && $stable(RDATA_OUT))
        else $error("read data not held");
    a_write_refused: assert property (
        BVALID_OUT |-> !AWREADY_OUT && !WREADY_OUT)
        else $error("write accepted while response pending");
    a_read_refused: assert property (
        RVALID_OUT |-> !ARREADY_OUT)
        else $error("read accepted while data pending");
    a_rdata_upper: assert property (
        RVALID_OUT |-> RDATA_OUT[31:8] == 24'h0)
        else $error("read data upper bits not zero");
endmodule
bind pmt_timer pmt_timer_asserts u_pmt_timer_asserts (.*);

//--- dv/tb_pmt_timer.sv
// self-checking bench for the period match timer
`timescale 1ns/10ps
`include "pmt_cfg.svh"
module tb_pmt_timer;
    logic clk, rst_n, sleep, awv, wv, bready, arv, rready;
    logic ce;
    logic [3:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic awrdy, wrdy, bvalid, arrdy, rvalid, match, irq;
    logic [1:0] bresp, rresp;
    int err_total = 0;
    int n_tests = 0;
    int cyc = 0;
    pmt_timer u_pmt_timer (
        .MCLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(ce), .SLEEP_IN(sleep),
        .AWADDR_IN(awaddr), .AWVALID_IN(awv), .AWREADY_OUT(awrdy),
        .WDATA_IN(wdata), .WSTRB_IN(4'h1), .WVALID_IN(wv),
        .WREADY_OUT(wrdy), .BRESP_OUT(bresp), .BVALID_OUT(bvalid),
        .BREADY_IN(bready), .ARADDR_IN(araddr), .ARVALID_IN(arv),
        .ARREADY_OUT(arrdy), .RDATA_OUT(rdata), .RRESP_OUT(rresp),
        .RVALID_OUT(rvalid), .RREADY_IN(rready),
        .PERIOD_MATCH_PULSE_OUT(match), .MATCH_IRQ_OUT(irq)
    );
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task results;
        $display("tests %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] r);
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        do begin
            @(posedge clk);
            if (awrdy === 1'b1) awv <= 1'b0;
            if (wrdy === 1'b1) wv <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b1;
        @(posedge clk);
        bready <= 1'b0;
        chk(bresp, r);
    endtask
    task rd(input logic [3:0] a, input logic [7:0] d, input logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arv <= 1'b1;
        do begin
            @(posedge clk);
            if (arrdy === 1'b1) arv <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b1;
        @(posedge clk);
        rready <= 1'b0;
        chk(rresp, r);
        if (r == 2'b00) chk(rdata, {24'h0, d});
    endtask
    task gap(output int n);
        while (match !== 1'b1) @(negedge clk);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (match !== 1'b1);
    endtask
    task t_regs;
        rd(`PMT_OFF_CONTROL, `PMT_CONTROL_RST, 2'b00);
        rd(`PMT_OFF_COUNT, `PMT_COUNT_RST, 2'b00);
        rd(`PMT_OFF_PERIOD, `PMT_PERIOD_RST, 2'b00);
        rd(`PMT_OFF_FLAG, 8'h00, 2'b00);
        wr(`PMT_OFF_PERIOD, 8'h03, 2'b00);
        rd(`PMT_OFF_PERIOD, 8'h03, 2'b00);
        rd(4'h2, 8'h00, 2'b10);
        wr(4'h2, 8'h5a, 2'b10);
    endtask
    task t_pre;
        int n;
        wr(`PMT_OFF_COUNT, 8'h00, 2'b00);
        for (int c = 0; c < 4; c++) begin
            wr(`PMT_OFF_CONTROL, {6'h01, c[1:0]}, 2'b00);
            gap(n);
            gap(n);
            chk(n, 16 << (2 * c));
        end
    endtask
    task t_post;
        int k;
        wr(`PMT_OFF_PERIOD, 8'h00, 2'b00);
        for (int n = 0; n < 16; n++) begin
            wr(`PMT_OFF_CONTROL, 8'h00, 2'b00);
            wr(`PMT_OFF_COUNT, 8'h00, 2'b00);
            wr(`PMT_OFF_FLAG, 8'h02, 2'b00);
            wr(`PMT_OFF_CONTROL, {1'b0, n[3:0], 3'h4}, 2'b00);
            k = 0;
            while (irq !== 1'b1) begin
                @(negedge clk);
                if (match === 1'b1) k++;
            end
            chk(k, n + 1);
        end
        wr(`PMT_OFF_FLAG, 8'h00, 2'b00);
        repeat (90) @(posedge clk);
        rd(`PMT_OFF_FLAG, 8'h01, 2'b00);
        chk(irq, 1'b0);
    endtask
    task t_hold;
        wr(`PMT_OFF_CONTROL, 8'h00, 2'b00);
        wr(`PMT_OFF_PERIOD, 8'h20, 2'b00);
        wr(`PMT_OFF_COUNT, 8'h05, 2'b00);
        repeat (20) @(posedge clk);
        rd(`PMT_OFF_COUNT, 8'h05, 2'b00);
        wr(`PMT_OFF_CONTROL, 8'h01, 2'b00);
        rd(`PMT_OFF_COUNT, 8'h05, 2'b00);
        sleep <= 1'b1;
        wr(`PMT_OFF_CONTROL, 8'h04, 2'b00);
        repeat (40) @(posedge clk);
        rd(`PMT_OFF_COUNT, 8'h05, 2'b00);
        rd(`PMT_OFF_PERIOD, 8'h20, 2'b00);
        sleep <= 1'b0;
    endtask
    // clock enable low for 40 edges stretches one match gap
    task t_ce;
        int n;
        int t0;
        wr(`PMT_OFF_COUNT, 8'h00, 2'b00);
        wr(`PMT_OFF_PERIOD, 8'h03, 2'b00);
        wr(`PMT_OFF_CONTROL, 8'h04, 2'b00);
        gap(n);
        chk(n, 16);
        t0 = cyc;
        @(posedge clk);
        ce <= 1'b0;
        repeat (40) @(posedge clk);
        ce <= 1'b1;
        while (match !== 1'b1) @(negedge clk);
        chk(cyc - t0, 56);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_total++;
            results;
        end
    end
    initial begin
        rst_n = 1'b0;
        sleep = 1'b0;
        ce = 1'b1;
        awv = 1'b0;
        wv = 1'b0;
        bready = 1'b0;
        arv = 1'b0;
        rready = 1'b0;
        awaddr = 4'h0;
        araddr = 4'h0;
        wdata = 32'h0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_regs;
        t_pre;
        t_post;
        t_hold;
        t_ce;
        results;
    end
endmodule
